// >>> async_serial_transceiver_core.sv
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module async_serial_transceiver_core #(
  parameter int FIFO_DEPTH = uart_pkg::FIFO_DEPTH
) (
  // Clock, reset and clock enable.
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  // Avalon-MM slave.
  input  wire logic [uart_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  // Serial link.
  input  wire logic                        serial_in_pin,
  output logic                             serial_out_pin,
  output logic                             serial_out_oe,
  // Event pulses toward the interrupt flags.
  output logic                             tx_irq_event,
  output logic                             rx_irq_event
);
  import uart_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam int RW = DATA_W + 2;
  localparam logic [CW-1:0] CNT_FULL  = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] CNT_THREE = CW'(FIFO_DEPTH - 1);

  // Configuration and control state.
  logic        module_enable, loopback_enable, stop_count_select;
  logic [1:0]  format_select, rx_irq_select;
  logic        tx_irq_select, send_break_bit, transmit_enable, address_detect_enable, overrun_flag;
  logic [15:0] baud_divisor_register, brg_cnt;
  logic        sync1, sync2, sync3, rx_line;
  // Transmit path.
  logic [PW-1:0] tx_wptr, tx_rptr;
  logic [CW-1:0] tx_count;
  logic [DATA_W-1:0] tx_head;
  logic [12:0] transmit_shifter;
  logic [3:0]  tx_left, tx_phase;
  logic        tx_busy;
  // Receive path.
  rx_state_e   rx_state;
  logic [PW-1:0] rx_wptr, rx_rptr;
  logic [CW-1:0] rx_count;
  logic [RW-1:0] rx_head;
  logic [12:0] receive_shifter;
  logic [3:0]  rx_phase, rx_idx;

  // Merge written byte lanes into a 16-bit register value.
  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
  endfunction : merge16

  // Bus decode: the answer comes one cycle after the request is seen.
  wire req      = read | write;
  wire wr_acc   = write & ~waitrequest;
  wire rd_acc   = read & ~waitrequest;
  wire sel_mode = (address == OFF_MODE);
  wire sel_stat = (address == OFF_STAT);
  wire sel_txd  = (address == OFF_TXD);
  wire sel_rxd  = (address == OFF_RXD);
  wire sel_baud = (address == OFF_BAUD);
  wire [15:0] mode_rd;
  wire [15:0] stat_rd;
  wire [15:0] mode_wr = merge16(mode_rd, writedata, byteenable);
  wire [15:0] stat_wr = merge16(stat_rd, writedata, byteenable);

  // Format decode shared by both directions.
  wire fmt9    = (format_select == FMT_9N);
  wire par_en  = (format_select == FMT_8E) | (format_select == FMT_8O);
  wire fmt_odd = (format_select == FMT_8O);
  wire [3:0] frame_bits = FRAME_BASE + {3'h0, par_en} + {3'h0, fmt9} + {3'h0, stop_count_select};

  // Baud tick at sixteen times the bit rate.
  wire tick = module_enable & (brg_cnt == baud_divisor_register);

  // Transmit FIFO control.
  wire tx_full  = (tx_count == CNT_FULL);
  wire tx_push  = wr_acc & sel_txd & byteenable[0] & module_enable & ~tx_full;
  wire tx_load  = module_enable & transmit_enable & ~send_break_bit & ~tx_busy & (tx_count != '0);
  wire [CW-1:0] next_tx_count = tx_count + CW'(tx_push) - CW'(tx_load);
  wire [PW-1:0] next_tx_rptr  = tx_load ? PW'(tx_rptr + 1'b1) : tx_rptr;
  wire tx_parity = (^tx_head[7:0]) ^ fmt_odd;
  wire [12:0] tx_frame = fmt9 ? {3'h7, tx_head[8:0], 1'b0} :
                         (par_en ? {3'h7, tx_parity, tx_head[7:0], 1'b0} : {4'hF, tx_head[7:0], 1'b0});
  wire shifter_empty_status = ~tx_busy;

  // Receive decode of the captured frame.
  wire rx_in = loopback_enable ? serial_out_pin : rx_line;
  wire [3:0] stop_last  = frame_bits - 4'h1;
  wire [3:0] stop_first = stop_last - {3'h0, stop_count_select};
  wire rx_framing_error_flag = ~receive_shifter[stop_last] | ~receive_shifter[stop_first];
  wire rx_parity_error_flag = par_en & ((^receive_shifter[9:1]) ^ fmt_odd);
  wire [DATA_W-1:0] rx_data = fmt9 ? receive_shifter[9:1] : {1'b0, receive_shifter[8:1]};
  wire rx_full  = (rx_count == CNT_FULL);
  wire rx_push  = (rx_state == RX_FINISH) & ~rx_full;
  wire rx_ovf   = (rx_state == RX_FINISH) & rx_full;
  wire rx_pop   = rd_acc & sel_rxd & (rx_count != '0);
  wire [CW-1:0] next_rx_count = rx_count + CW'(rx_push) - CW'(rx_pop);
  wire [PW-1:0] next_rx_rptr  = rx_pop ? PW'(rx_rptr + 1'b1) : rx_rptr;
  wire rx_data_available    = (rx_count != '0);
  wire receiver_idle_status = (rx_state != RX_BUSY) & (rx_state != RX_FINISH);
  wire addr_mode = address_detect_enable & fmt9;
  wire rx_level_hit = (rx_irq_select[1] == 1'b0) | (rx_irq_select[0] ? (next_rx_count == CNT_FULL) : (next_rx_count == CNT_THREE));

  // Register readback assembly; error flags follow the head character.
  assign mode_rd = {module_enable, 8'h00, loopback_enable, 3'h0, format_select, stop_count_select};
  assign stat_rd = {tx_irq_select, 3'h0, send_break_bit, transmit_enable, tx_full, shifter_empty_status,
                    rx_irq_select, address_detect_enable, receiver_idle_status,
                    rx_data_available & rx_head[DATA_W+1], rx_data_available & rx_head[DATA_W],
                    overrun_flag, rx_data_available};
  wire [15:0] rd_mux = sel_mode ? mode_rd : sel_stat ? stat_rd : sel_rxd ? {7'h00, rx_head[DATA_W-1:0]} :
                       sel_baud ? baud_divisor_register : 16'h0000;

  // Bus handshake: waitrequest drops for one cycle, with read data, after a request appears.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      waitrequest <= ~(req & waitrequest);
      if (read & waitrequest) begin
        readdata <= {16'h0000, rd_mux};
      end
    end
  end

  // Mode and divisor registers; disabling the module leaves them untouched.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {module_enable, loopback_enable, format_select, stop_count_select} <=
        {MODE_RESET[MODE_EN_BIT], MODE_RESET[MODE_LOOP_BIT], MODE_RESET[MODE_FMT_LSB+:2], MODE_RESET[MODE_STOP_BIT]};
      baud_divisor_register <= BAUD_RESET;
    end else if (clk_en) begin
      if (wr_acc && sel_mode) begin
        module_enable     <= mode_wr[MODE_EN_BIT];
        loopback_enable   <= mode_wr[MODE_LOOP_BIT];
        format_select     <= mode_wr[MODE_FMT_LSB+:2];
        stop_count_select <= mode_wr[MODE_STOP_BIT];
      end
      if (wr_acc && sel_baud) begin
        baud_divisor_register <= merge16(baud_divisor_register, writedata, byteenable);
      end
    end
  end

  // Status control bits; an overrun in the same cycle as its clear wins.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {tx_irq_select, send_break_bit, transmit_enable} <= {STAT_RESET[STAT_TXISEL_BIT], STAT_RESET[STAT_BRK_BIT], STAT_RESET[STAT_TXEN_BIT]};
      rx_irq_select         <= STAT_RESET[STAT_RXISEL_LSB+:2];
      address_detect_enable <= STAT_RESET[STAT_ADDRESS_DETECT_ENABLE_BIT];
      overrun_flag          <= STAT_RESET[STAT_OVF_BIT];
    end else if (clk_en) begin
      if (wr_acc && sel_stat) begin
        tx_irq_select         <= stat_wr[STAT_TXISEL_BIT];
        send_break_bit        <= stat_wr[STAT_BRK_BIT];
        transmit_enable       <= stat_wr[STAT_TXEN_BIT];
        rx_irq_select         <= stat_wr[STAT_RXISEL_LSB+:2];
        address_detect_enable <= stat_wr[STAT_ADDRESS_DETECT_ENABLE_BIT];
        if (!stat_wr[STAT_OVF_BIT]) begin
          overrun_flag <= 1'b0;
        end
      end
      if (rx_ovf) begin
        overrun_flag <= 1'b1;
      end
      if (!module_enable) begin
        {send_break_bit, transmit_enable, overrun_flag} <= 3'h0;
      end
    end
  end

  // Input synchroniser with agreement filter on the last two stages.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {sync1, sync2, sync3, rx_line} <= 4'hF;
    end else if (clk_en) begin
      sync1 <= serial_in_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        rx_line <= sync3;
      end
    end
  end

  // Baud divisor counter, cleared while the module is disabled.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      brg_cnt <= 16'h0000;
    end else if (clk_en) begin
      brg_cnt <= (!module_enable || tick) ? 16'h0000 : brg_cnt + 16'h0001;
    end
  end

  // Transmit FIFO pointers; reset or disable empties the queue.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {tx_wptr, tx_rptr, tx_count} <= '0;
    end else if (clk_en) begin
      if (!module_enable) begin
        {tx_wptr, tx_rptr, tx_count} <= '0;
      end else begin
        tx_wptr  <= tx_push ? PW'(tx_wptr + 1'b1) : tx_wptr;
        tx_rptr  <= next_tx_rptr;
        tx_count <= next_tx_count;
      end
    end
  end

  fifo_mem #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(PW)) tx_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .we      (tx_push),
    .waddr   (tx_wptr),
    .wdata   (writedata[DATA_W-1:0]),
    .raddr   (next_tx_rptr),
    .rdata   (tx_head)
  );

  // Transmit shifter: load starts the start bit, each bit lasts sixteen ticks.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      transmit_shifter <= 13'h1FFF;
      {tx_left, tx_phase, tx_busy} <= '0;
    end else if (clk_en) begin
      if (!module_enable) begin
        tx_busy <= 1'b0;
      end else if (tx_load) begin
        transmit_shifter <= tx_frame;
        tx_left          <= frame_bits;
        tx_phase         <= 4'h0;
        tx_busy          <= 1'b1;
      end else if (tx_busy && tick) begin
        tx_phase <= tx_phase + 4'h1;
        if (tx_phase == LAST_PHASE) begin
          transmit_shifter <= {1'b1, transmit_shifter[12:1]};
          tx_left          <= tx_left - 4'h1;
          tx_busy          <= (tx_left != 4'h1);
        end
      end
    end
  end

  // Output pin and transmit event.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
      tx_irq_event   <= 1'b0;
    end else if (clk_en) begin
      serial_out_oe  <= module_enable;
      serial_out_pin <= ~module_enable | (~send_break_bit & (~tx_busy | transmit_shifter[0]));
      tx_irq_event   <= tx_load & (~tx_irq_select | (next_tx_count == '0));
    end
  end

  // Receiver state machine, sampling each bit at its middle tick.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_state        <= RX_IDLE;
      receive_shifter <= 13'h1FFF;
      {rx_phase, rx_idx} <= '0;
    end else if (clk_en) begin
      if (!module_enable) begin
        rx_state <= RX_IDLE;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (tick && !rx_in) begin
              rx_state <= RX_BUSY;
              rx_phase <= 4'h0;
              rx_idx   <= 4'h0;
            end
          end
          RX_BUSY: begin
            if (tick) begin
              rx_phase <= rx_phase + 4'h1;
              if (rx_phase == SAMPLE_PHASE) begin
                receive_shifter[rx_idx] <= rx_in;
                rx_idx <= rx_idx + 4'h1;
                if (rx_idx == 4'h0 && rx_in) begin
                  rx_state <= RX_IDLE;
                end else if (rx_idx == stop_last) begin
                  rx_state <= RX_FINISH;
                end
              end
            end
          end
          RX_FINISH: begin
            rx_state <= rx_full ? RX_HOLD : (rx_framing_error_flag ? RX_WAIT : RX_IDLE);
          end
          RX_WAIT: begin
            if (rx_in) begin
              rx_state <= RX_IDLE;
            end
          end
          RX_HOLD: begin
            if (!overrun_flag) begin
              rx_state <= RX_IDLE;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive FIFO pointers and receive event.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {rx_wptr, rx_rptr, rx_count} <= '0;
      rx_irq_event <= 1'b0;
    end else if (clk_en) begin
      if (!module_enable) begin
        {rx_wptr, rx_rptr, rx_count} <= '0;
      end else begin
        rx_wptr  <= rx_push ? PW'(rx_wptr + 1'b1) : rx_wptr;
        rx_rptr  <= next_rx_rptr;
        rx_count <= next_rx_count;
      end
      rx_irq_event <= module_enable & rx_push & (addr_mode ? rx_data[DATA_W-1] : rx_level_hit);
    end
  end

  fifo_mem #(.WIDTH(RW), .DEPTH(FIFO_DEPTH), .AW(PW)) rx_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .we      (rx_push),
    .waddr   (rx_wptr),
    .wdata   ({rx_parity_error_flag, rx_framing_error_flag, rx_data}),
    .raddr   (next_rx_rptr),
    .rdata   (rx_head)
  );

  // Checks on the block's own behaviour.
  default clocking chk @(posedge clk_sys iff clk_en); endclocking
  default disable iff (!resetn);

  a_tx_full_drop: assert property (tx_push == 1'b0 || !tx_full) else $error("push accepted into full transmit FIFO");
  a_tx_full_keep: assert property (tx_full && !tx_load && module_enable |=> tx_count == CNT_FULL) else $error("full FIFO lost data");
  a_tx_depth_cap: assert property (tx_count <= CNT_FULL) else $error("transmit FIFO over depth");
  a_break_low: assert property (send_break_bit && module_enable |=> !serial_out_pin) else $error("break did not hold line low");
  a_break_no_event: assert property (send_break_bit |=> !tx_irq_event) else $error("event raised during break");
  a_idle_line_high: assert property (module_enable && !tx_busy && !send_break_bit |=> serial_out_pin) else $error("idle line not high");
  a_tx_event_cause: assert property (tx_irq_event |-> $past(tx_load) && ($past(!tx_irq_select) || tx_count == '0)) else $error("transmit event without cause");
  a_rx_empty_read: assert property (rd_acc && sel_rxd && rx_count == '0 |=> $stable(rx_rptr)) else $error("empty read moved FIFO");
  a_rx_event_cause: assert property (rx_irq_event |-> $past(rx_push)) else $error("receive event without push");
  a_ovf_halt: assert property (rx_state == RX_HOLD |=> (rx_push == 1'b0)) else $error("reception continued in overrun");
  a_disable_clear: assert property (!module_enable |=> tx_count == '0 && rx_count == '0 && !overrun_flag && !tx_busy) else $error("disable left state");
  a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bus answer not one cycle");
  a_rx_idle_busy: assert property (rx_state == RX_BUSY |-> !receiver_idle_status) else $error("idle high during frame");

  c_tx_load: cover property (tx_load ##[1:1000] tx_irq_event);
  c_rx_push: cover property (rx_push ##1 rx_irq_event);
  c_overrun: cover property (rx_ovf);
  c_break: cover property (send_break_bit && tx_count != '0);

endmodule : async_serial_transceiver_core

// >>> async_serial_transceiver_core_bench.sv
`timescale 1ns/1ps
module async_serial_transceiver_core_bench;
  import uart_pkg::*;
  logic        clk_sys, resetn, read, write, waitrequest, rx_line, tx_line, tx_ev, rx_ev;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [15:0] q;
  int          errors, samples_checked, tx_events, rx_events, ev;
  // Design and the remote node on its serial pins.
  async_serial_transceiver_core i_async_serial_transceiver_core (.clk_sys(clk_sys), .resetn(resetn),
    .clk_en(1'b1), .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .serial_in_pin(rx_line), .serial_out_pin(tx_line),
    .serial_out_oe(), .tx_irq_event(tx_ev), .rx_irq_event(rx_ev));
  serial_node i_serial_node (.line_in(tx_line), .line_out(rx_line));
  // Clock at 100 ns.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Counts event pulses.
  always @(posedge clk_sys) begin
    if (tx_ev === 1'b1) tx_events++;
    if (rx_ev === 1'b1) rx_events++;
  end
  // Compares one result.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata[15:0];
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) errors++;
  endtask : bus
  // Prints the counts and the verdict.
  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the expected run.
  initial begin
    #3000000;
    errors++;
    finish_test();
  end
  // Main sequence.
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h00000000;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(0, OFF_MODE, 0, q); chk("mode", 16'h0000, q);
    bus(0, OFF_STAT, 0, q); chk("status", 16'h0110, q);
    bus(0, 5'h14, 0, q); chk("unmapped", 16'h0000, q);
    bus(1, OFF_BAUD, 16'hFFFF, q);
    bus(0, OFF_BAUD, 0, q); chk("baud", 16'hFFFF, q);
    bus(1, OFF_BAUD, 16'h0000, q);
    bus(1, OFF_MODE, 16'h8000, q);
    bus(1, OFF_STAT, 16'h0400, q);
    for (int i = 1; i <= 6; i++) bus(1, OFF_TXD, 16'(i * 17), q);
    bus(0, OFF_STAT, 0, q); chk("tx_full", 16'h0001, 16'(q[9]));
    repeat (1000) @(posedge clk_sys);
    chk("tx_count", 16'h0005, 16'(i_serial_node.got.size()));
    for (int i = 0; i < 5; i++) chk("tx_byte", 16'((i + 1) * 17), 16'(i_serial_node.got[i]));
    chk("tx_events", 16'h0005, 16'(tx_events));
    chk("tx_idle", 16'h0001, 16'(tx_line));
    i_serial_node.send(8'hA5);
    repeat (10) @(posedge clk_sys);
    bus(0, OFF_STAT, 0, q); chk("rx_avail", 16'h0001, 16'(q[0]));
    bus(0, OFF_RXD, 0, q); chk("rx_data", 16'h00A5, q);
    bus(0, OFF_STAT, 0, q); chk("rx_empty", 16'h0000, 16'(q[0]));
    chk("rx_events", 16'h0001, 16'(rx_events));
    bus(1, OFF_MODE, 16'h8040, q);
    bus(1, OFF_TXD, 16'h003C, q);
    repeat (200) @(posedge clk_sys);
    bus(0, OFF_RXD, 0, q); chk("loop_data", 16'h003C, q);
    chk("loop_pin", 16'h003C, 16'(i_serial_node.got[5]));
    // Break held past thirteen bit times, then cleared; the looped-back frame ends in a framing error.
    bus(1, OFF_STAT, 16'h0C00, q);
    repeat (4) @(posedge clk_sys);
    chk("break", 16'h0000, 16'(tx_line));
    repeat (208) @(posedge clk_sys);
    bus(1, OFF_STAT, 16'h0400, q);
    repeat (40) @(posedge clk_sys);
    chk("break_end", 16'h0001, 16'(tx_line));
    bus(0, OFF_STAT, 0, q); chk("break_flags", 16'h0005, q & 16'h0005);
    bus(0, OFF_RXD, 0, q); chk("break_data", 16'h0000, q);
    // Nine-bit word with the ninth bit set, address detect on.
    bus(1, OFF_MODE, 16'h8046, q);
    bus(1, OFF_STAT, 16'h0420, q);
    ev = rx_events;
    bus(1, OFF_TXD, 16'h0155, q);
    repeat (220) @(posedge clk_sys);
    chk("addr_event", 16'h0001, 16'(rx_events - ev));
    bus(0, OFF_RXD, 0, q); chk("data9", 16'h0155, q);
    finish_test();
  end
endmodule : async_serial_transceiver_core_bench

// >>> fifo_mem.sv
`timescale 1ns/1ps
module fifo_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // Write port.
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port, fed with the next read pointer.
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage array; contents need no reset because the pointers define validity.
  always_ff @(posedge clk_sys) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register with write-through so that it always mirrors the head entry.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= (we && (waddr == raddr)) ? wdata : mem[raddr];
    end
  end

endmodule : fifo_mem

// >>> serial_node.sv
`timescale 1ns/1ps
module serial_node #(
  parameter int BIT_NS = 1600
) (
  // Serial lines, seen from the remote node.
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got[$];
  logic [7:0] b;
  initial line_out = 1'b1;
  // Sends one 8N1 frame, least significant bit first.
  task automatic send(input logic [7:0] d);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = 1'b1;
    #(BIT_NS);
  endtask : send
  // Samples each incoming frame mid-bit and keeps it if the stop bit is high.
  always @(negedge line_in) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      b[i] = line_in;
    end
    #(BIT_NS);
    if (line_in) got.push_back(b);
  end
endmodule : serial_node

// >>> uart_pkg.sv
package uart_pkg;

  // Register bus geometry and byte offsets of the five registers.
  localparam int         ADDR_W   = 5;
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_TXD  = 5'h08;
  localparam logic [4:0] OFF_RXD  = 5'h0C;
  localparam logic [4:0] OFF_BAUD = 5'h10;

  // Field positions in the mode control register.
  localparam int MODE_EN_BIT   = 15;
  localparam int MODE_LOOP_BIT = 6;
  localparam int MODE_FMT_LSB  = 1;
  localparam int MODE_STOP_BIT = 0;

  // Field positions in the status control register.
  localparam int STAT_TXISEL_BIT = 15;
  localparam int STAT_BRK_BIT    = 11;
  localparam int STAT_TXEN_BIT   = 10;
  localparam int STAT_RXISEL_LSB = 6;
  localparam int STAT_ADDRESS_DETECT_ENABLE_BIT  = 5;
  localparam int STAT_OVF_BIT    = 1;

  // Reset values: 8 data bits, no parity, one stop bit, divisor zero.
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0110;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // Character formats selected by format_select.
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;

  // Timing: 16 baud ticks per bit, sample in the middle, frame base length.
  localparam int         CLK_PERIOD_NS = 100;
  localparam int         OVERSAMPLE    = 16;
  localparam logic [3:0] LAST_PHASE    = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SAMPLE_PHASE  = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] FRAME_BASE    = 4'hA;
  localparam int         FIFO_DEPTH    = 4;
  localparam int         DATA_W        = 9;

  // Receiver states.
  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_BUSY   = 5'b00010,
    RX_FINISH = 5'b00100,
    RX_WAIT   = 5'b01000,
    RX_HOLD   = 5'b10000
  } rx_state_e;

endpackage : uart_pkg
